/* core/rail_setpoint_pkg.sv */
package rail_setpoint_pkg;

  // register map
  localparam logic [7:0] SLEW_CONTROL_OFFSET    = 8'h1A;
  localparam logic [7:0] LINEAR_REG_OFFSET      = 8'h1B;

  // reset values
  localparam logic [7:0] SLEW_CONTROL_RESET     = 8'h06;
  localparam logic [7:0] LINEAR_REG_RESET       = 8'h1F;
  localparam logic [7:0] UNMAPPED_READ_VALUE    = 8'h00;

  // slew_control fields
  localparam int         TRIGGER_BIT            = 7;
  localparam int         AUTO_APPLY_BIT         = 6;
  localparam int         SLEW_FIELD_LSB         = 0;
  localparam int         SLEW_FIELD_W           = 3;
  localparam logic [2:0] SLEW_FIELD_RESET       = 3'h6;
  localparam logic [2:0] SLEW_FASTEST           = 3'h7;

  // linear regulator field and voltage decode
  localparam int         LINEAR_CODE_LSB        = 0;
  localparam int         LINEAR_CODE_W          = 6;
  localparam logic [5:0] LINEAR_CODE_RESET      = 6'h1F;
  localparam logic [5:0] FINE_LAST_CODE         = 6'h19;
  localparam logic [5:0] COARSE_FIRST_CODE      = 6'h1A;
  localparam int         FINE_BASE_MV           = 900;
  localparam int         FINE_STEP_MV           = 25;
  localparam int         COARSE_BASE_MV         = 1550;
  localparam int         COARSE_STEP_MV         = 50;
  localparam int         MV_W                   = 12;

  // buck set-point codes
  localparam int         BUCK_CODE_W            = 6;
  localparam logic [5:0] BUCK_OUTPUT_RESET      = 6'h00;

  // timing
  localparam int         CLK_HZ                 = 50_000_000;
  localparam int         BLANK_TIME_MS          = 5;
  localparam int         BLANK_CYCLES           = BLANK_TIME_MS * (CLK_HZ / 1000);
  localparam int         SLEW_STEP_BASE_NS      = 1000;
  localparam int         SLEW_STEP_BASE_CYCLES  = (SLEW_STEP_BASE_NS * (CLK_HZ / 1_000_000)
                                                   + 999) / 1000;
  localparam int         STEP_CNT_W             = 16;

endpackage : rail_setpoint_pkg

/* core/blank_timer.sv */
`timescale 1ns/10ps
module blank_timer #(
  parameter int COUNT = rail_setpoint_pkg::BLANK_CYCLES
) (
  input  wire logic core_clk_i,
  input  wire logic resetn_i,
  input  wire logic start_i,
  output logic      blank_o
);

  localparam int CNT_W = $clog2(COUNT + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(COUNT - 1);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             next_blank;

  // a new write restarts the full interval
  always_comb begin
    next_count = count;
    next_blank = blank_o;
    if (start_i) begin
      next_count = '0;
      next_blank = 1'b1;
    end else if (blank_o) begin
      if (count == LAST) begin
        next_blank = 1'b0;
      end else begin
        next_count = count + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      count   <= '0;
      blank_o <= 1'b0;
    end else begin
      count   <= next_count;
      blank_o <= next_blank;
    end
  end

endmodule : blank_timer

/* core/ramp_engine.sv */
`timescale 1ns/10ps
module ramp_engine #(
  parameter int                CODE_W    = rail_setpoint_pkg::BUCK_CODE_W,
  parameter logic [CODE_W-1:0] PRESET    = rail_setpoint_pkg::BUCK_OUTPUT_RESET,
  parameter int                STEP_BASE = rail_setpoint_pkg::SLEW_STEP_BASE_CYCLES
) (
  input  wire logic              core_clk_i,
  input  wire logic              resetn_i,
  input  wire logic              start_i,
  input  wire logic [2:0]        slew_i,
  input  wire logic [CODE_W-1:0] target_one_i,
  input  wire logic [CODE_W-1:0] target_two_i,
  output logic      [CODE_W-1:0] present_one_o,
  output logic      [CODE_W-1:0] present_two_o,
  output logic                   busy_o,
  output logic                   done_o
);

  localparam int SW = rail_setpoint_pkg::STEP_CNT_W;

  typedef enum logic [1:0] {
    IDLE = 2'b01,
    RAMP = 2'b10
  } ramp_state_t;

  ramp_state_t       state;
  ramp_state_t       next_state;
  logic [SW-1:0]     tick;
  logic [SW-1:0]     next_tick;
  logic [SW-1:0]     interval;
  logic [CODE_W-1:0] target      [2];
  logic [CODE_W-1:0] next_target [2];
  logic [CODE_W-1:0] present     [2];
  logic [CODE_W-1:0] next_present[2];
  logic [CODE_W-1:0] stepped     [2];
  logic [1:0]        reached;
  logic              next_done;

  // larger slew code steps faster; each step moves one code
  assign interval = SW'(STEP_BASE) << (rail_setpoint_pkg::SLEW_FASTEST - slew_i);

  generate
    for (genvar r = 0; r < 2; r++) begin : g_rail
      assign reached[r] = (present[r] == target[r]);
      assign stepped[r] = reached[r] ? present[r] :
                          (present[r] < target[r]) ? present[r] + CODE_W'(1)
                                                   : present[r] - CODE_W'(1);
    end
  endgenerate

  always_comb begin
    next_state   = state;
    next_tick    = tick;
    next_target  = target;
    next_present = present;
    next_done    = 1'b0;
    if (start_i) begin
      next_target[0] = target_one_i;
      next_target[1] = target_two_i;
      next_tick      = '0;
      next_state     = RAMP;
    end else begin
      case (state)
        IDLE: next_tick = '0;
        RAMP: begin
          if (&reached) begin
            next_done  = 1'b1;
            next_state = IDLE;
          end else if (tick >= interval - SW'(1)) begin
            next_tick    = '0;
            next_present = stepped;
          end else begin
            next_tick = tick + SW'(1);
          end
        end
        default: next_state = IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      state   <= IDLE;
      tick    <= '0;
      target  <= '{PRESET, PRESET};
      present <= '{PRESET, PRESET};
      done_o  <= 1'b0;
    end else begin
      state   <= next_state;
      tick    <= next_tick;
      target  <= next_target;
      present <= next_present;
      done_o  <= next_done;
    end
  end

  assign present_one_o = present[0];
  assign present_two_o = present[1];
  assign busy_o        = state[1];

endmodule : ramp_engine

/* core/rail_setpoint_registers.sv */
// What this block does
// [R01] Slew pacing and triggered transitions act on the two buck converters and nothing else.
// [R02] Host clears light-load mode before lowering an unloaded buck under tight supervision.
// [R03] A 1 in slew control bit 7 ramps both bucks to their stored set-points; a 0 does nothing.
// [R04] The trigger bit clears itself when the transition ends, so later reads return 0.
// [R05] With bit 6 set, a buck set-point write starts a paced transition with no trigger.
// [R06] Slew control sits at 0x1A and resets to 0x06.
// [R07] The linear regulator register sits at 0x1B and resets to 0x1F, the 1.8 V setting.
// [R08] Writes to the linear regulator register take effect only while the password unlock holds.
// [R09] Each linear regulator write blanks over- and under-voltage monitoring for 5 ms; here a write refused while locked does not blank.
// [R10] Code 0 is 0.900 V, +25 mV per step to 19h, then 1.550 V at 1Ah and +50 mV to 3.400 V.
// [R11] Bits 2 to 0 of slew control are a read-write slew-rate field resetting to 110b.
// [R12] Reserved bits read as zero and ignore writes.
`timescale 1ns/10ps
module rail_setpoint_registers #(
  parameter int BLANK_COUNT = rail_setpoint_pkg::BLANK_CYCLES,
  parameter int STEP_BASE   = rail_setpoint_pkg::SLEW_STEP_BASE_CYCLES
) (
  input  wire logic       core_clk_i,
  input  wire logic       resetn_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       unlock_i,
  input  wire logic [5:0] buck_one_setpoint_i,
  input  wire logic [5:0] buck_two_setpoint_i,
  input  wire logic       buck_setpoint_wr_i,
  output logic      [5:0] buck_one_output_o,
  output logic      [5:0] buck_two_output_o,
  output logic            ramp_busy_o,
  output logic      [5:0] linear_regulator_code_o,
  output logic     [11:0] linear_regulator_mv_o,
  output logic            ldo_fault_blank_o,
  output logic            ldo_write_refused_o
);

  localparam int CW = rail_setpoint_pkg::BUCK_CODE_W;
  localparam int LW = rail_setpoint_pkg::LINEAR_CODE_W;
  localparam int MW = rail_setpoint_pkg::MV_W;

  // ---- address decode, shared by read and write paths
  function automatic logic hits(input logic [7:0] addr, input logic [7:0] offset);
    hits = (addr == offset);
  endfunction : hits

  // ---- regulator code to millivolts
  function automatic logic [11:0] code_to_mv(input logic [5:0] code);
    logic [11:0] fine;
    logic [11:0] coarse;
    fine   = 12'(rail_setpoint_pkg::FINE_BASE_MV)
           + 12'(rail_setpoint_pkg::FINE_STEP_MV) * 12'(code);
    coarse = 12'(rail_setpoint_pkg::COARSE_BASE_MV)
           + 12'(rail_setpoint_pkg::COARSE_STEP_MV)
           * 12'(code - rail_setpoint_pkg::COARSE_FIRST_CODE);
    if (code <= rail_setpoint_pkg::FINE_LAST_CODE) begin
      code_to_mv = fine;
    end else begin
      code_to_mv = coarse;
    end
  endfunction : code_to_mv

  logic           wr_slew;
  logic           wr_linear;
  logic           rd_slew;
  logic           rd_linear;

  assign wr_slew   = reg_wr_i && hits(reg_addr_i, rail_setpoint_pkg::SLEW_CONTROL_OFFSET);  // [R06]
  assign wr_linear = reg_wr_i && hits(reg_addr_i, rail_setpoint_pkg::LINEAR_REG_OFFSET);    // [R07]
  assign rd_slew   = reg_rd_i && hits(reg_addr_i, rail_setpoint_pkg::SLEW_CONTROL_OFFSET);
  assign rd_linear = reg_rd_i && hits(reg_addr_i, rail_setpoint_pkg::LINEAR_REG_OFFSET);

  // ---- slew control state
  logic           trigger;
  logic           next_trigger;
  logic           auto_apply_select;
  logic           next_auto_apply_select;
  logic [2:0]     slew_rate;
  logic [2:0]     next_slew_rate;
  logic           ramp_start;
  logic           ramp_done;
  logic           engine_busy;
  logic [CW-1:0]  engine_one;
  logic [CW-1:0]  engine_two;
  logic           trigger_set;

  // a 1 in the trigger position is the only slew control write that launches a ramp
  assign trigger_set = wr_slew && reg_wdata_i[rail_setpoint_pkg::TRIGGER_BIT];  // [R03]

  // auto mode also launches on buck set-point writes; the trigger still works
  assign ramp_start = trigger_set
                   || (auto_apply_select && buck_setpoint_wr_i);  // [R05]

  always_comb begin
    next_trigger           = trigger;
    next_auto_apply_select = auto_apply_select;
    next_slew_rate         = slew_rate;
    if (ramp_done) begin
      next_trigger = 1'b0;  // [R04]
    end
    // set after clear: a relaunch in the finishing cycle keeps the bit up
    if (trigger_set) begin
      next_trigger = 1'b1;  // [R03]
    end
    if (wr_slew) begin
      next_auto_apply_select = reg_wdata_i[rail_setpoint_pkg::AUTO_APPLY_BIT];  // [R05]
      next_slew_rate = reg_wdata_i[rail_setpoint_pkg::SLEW_FIELD_LSB +:
                                   rail_setpoint_pkg::SLEW_FIELD_W];  // [R11]
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      trigger           <= rail_setpoint_pkg::SLEW_CONTROL_RESET[rail_setpoint_pkg::TRIGGER_BIT];
      auto_apply_select <=
        rail_setpoint_pkg::SLEW_CONTROL_RESET[rail_setpoint_pkg::AUTO_APPLY_BIT];
      slew_rate         <= rail_setpoint_pkg::SLEW_FIELD_RESET;  // [R06] [R11]
    end else begin
      trigger           <= next_trigger;
      auto_apply_select <= next_auto_apply_select;
      slew_rate         <= next_slew_rate;
    end
  end

  // only the two buck rails are wired to the ramp engine
  ramp_engine #(
    .CODE_W    (CW),
    .PRESET    (rail_setpoint_pkg::BUCK_OUTPUT_RESET),
    .STEP_BASE (STEP_BASE)
  ) u_ramp (
    .core_clk_i    (core_clk_i),
    .resetn_i      (resetn_i),
    .start_i       (ramp_start),
    .slew_i        (slew_rate),
    .target_one_i  (buck_one_setpoint_i),
    .target_two_i  (buck_two_setpoint_i),
    .present_one_o (engine_one),
    .present_two_o (engine_two),
    .busy_o        (engine_busy),
    .done_o        (ramp_done)
  );  // [R01]

  // ---- buck outputs registered once more so every port leaves a flop here
  logic [CW-1:0]  next_buck_one;
  logic [CW-1:0]  next_buck_two;
  logic           next_ramp_busy;

  always_comb begin
    next_buck_one  = engine_one;
    next_buck_two  = engine_two;
    next_ramp_busy = engine_busy;
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      buck_one_output_o <= rail_setpoint_pkg::BUCK_OUTPUT_RESET;
      buck_two_output_o <= rail_setpoint_pkg::BUCK_OUTPUT_RESET;
      ramp_busy_o       <= 1'b0;
    end else begin
      buck_one_output_o <= next_buck_one;  // [R01]
      buck_two_output_o <= next_buck_two;  // [R01]
      ramp_busy_o       <= next_ramp_busy;
    end
  end

  // ---- linear regulator state
  logic [LW-1:0]  linear_code;
  logic [LW-1:0]  next_linear_code;
  logic [MW-1:0]  next_linear_mv;
  logic           next_refused;
  logic           linear_accept;

  // a locked write is dropped whole, including its blanking side effect
  assign linear_accept = wr_linear && unlock_i;  // [R08]

  always_comb begin
    next_linear_code = linear_code;
    next_refused     = wr_linear && !unlock_i;  // [R08]
    if (linear_accept) begin
      next_linear_code = reg_wdata_i[rail_setpoint_pkg::LINEAR_CODE_LSB +: LW];  // [R12]
    end
    next_linear_mv = code_to_mv(next_linear_code);  // [R10]
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      linear_code           <= rail_setpoint_pkg::LINEAR_CODE_RESET;  // [R07]
      linear_regulator_mv_o <= code_to_mv(rail_setpoint_pkg::LINEAR_CODE_RESET);
      ldo_write_refused_o   <= 1'b0;
    end else begin
      linear_code           <= next_linear_code;
      linear_regulator_mv_o <= next_linear_mv;  // [R10]
      ldo_write_refused_o   <= next_refused;
    end
  end

  assign linear_regulator_code_o = linear_code;

  // rewriting the same code still blanks: the analog side may glitch anyway
  blank_timer #(
    .COUNT (BLANK_COUNT)
  ) u_blank (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .start_i    (linear_accept),
    .blank_o    (ldo_fault_blank_o)
  );  // [R09]

  // ---- read path, data in the cycle after the strobe
  logic [7:0]     slew_view;
  logic [7:0]     linear_view;
  logic [7:0]     next_rdata;

  always_comb begin
    slew_view = 8'h00;  // [R12]
    slew_view[rail_setpoint_pkg::TRIGGER_BIT]    = trigger;  // [R04]
    slew_view[rail_setpoint_pkg::AUTO_APPLY_BIT] = auto_apply_select;
    slew_view[rail_setpoint_pkg::SLEW_FIELD_LSB +: rail_setpoint_pkg::SLEW_FIELD_W] = slew_rate;
    linear_view = 8'h00;  // [R12]
    linear_view[rail_setpoint_pkg::LINEAR_CODE_LSB +: LW] = linear_code;
  end

  always_comb begin
    next_rdata = rail_setpoint_pkg::UNMAPPED_READ_VALUE;
    if (rd_slew) begin
      next_rdata = slew_view;
    end else if (rd_linear) begin
      next_rdata = linear_view;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

endmodule : rail_setpoint_registers

/* tb/rail_setpoint_chk.sv */
`timescale 1ns/10ps
module rail_setpoint_chk #(
  parameter int BLANK_COUNT = 20
) (
  input wire logic        core_clk_i,
  input wire logic        resetn_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        unlock_i,
  input wire logic [5:0]  buck_one_output_o,
  input wire logic [5:0]  buck_two_output_o,
  input wire logic        ramp_busy_o,
  input wire logic [5:0]  linear_regulator_code_o,
  input wire logic [11:0] linear_regulator_mv_o,
  input wire logic        ldo_fault_blank_o,
  input wire logic        ldo_write_refused_o
);
  int          blank_cnt;
  logic        ldo_take;
  logic [11:0] mv_exp;

  assign ldo_take = reg_wr_i && reg_addr_i == 8'h1B && unlock_i;
  assign mv_exp   = (linear_regulator_code_o <= 6'h19) ? 12'(900 + 25 * linear_regulator_code_o)
                  : 12'(1550 + 50 * (linear_regulator_code_o - 6'h1A));

  // restarts on every accepted write, so a retrigger gets a full window
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || ldo_take) blank_cnt <= 0;
    else if (ldo_fault_blank_o) blank_cnt <= blank_cnt + 1;
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside read");
  unmapped_read_a: assert property (reg_rd_i && reg_addr_i != 8'h1A && reg_addr_i != 8'h1B
    |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  slew_reserved_a: assert property (reg_rd_i && reg_addr_i == 8'h1A
    |=> reg_rdata_o[5:3] == 3'h0) else $error("slew reserved bits set");
  ldo_read_a: assert property (reg_rd_i && reg_addr_i == 8'h1B
    |=> reg_rdata_o == {2'h0, $past(linear_regulator_code_o)}) else $error("bad ldo read");
  ldo_write_a: assert property (ldo_take |=> ldo_fault_blank_o
    && {2'h0, linear_regulator_code_o} == ($past(reg_wdata_i) & 8'h3F)) else $error("ldo write");
  ldo_locked_a: assert property (reg_wr_i && reg_addr_i == 8'h1B && !unlock_i
    |=> ldo_write_refused_o && $stable(linear_regulator_code_o)) else $error("locked write");
  refused_cause_a: assert property (ldo_write_refused_o |-> $past(reg_wr_i)
    && !$past(unlock_i) && $past(reg_addr_i) == 8'h1B) else $error("spurious refusal");
  mv_decode_a: assert property (linear_regulator_mv_o == mv_exp)
    else $error("millivolt decode wrong");
  blank_len_a: assert property (ldo_fault_blank_o |-> blank_cnt < BLANK_COUNT)
    else $error("blanking too long");
  blank_end_a: assert property ($fell(ldo_fault_blank_o) |-> blank_cnt == BLANK_COUNT)
    else $error("blanking too short");
  ramp_one_a: assert property ($changed(buck_one_output_o) |-> $past(ramp_busy_o)
    && (6'(buck_one_output_o - $past(buck_one_output_o)) inside {6'h01, 6'h3F}))
    else $error("buck one step wrong");
  ramp_two_a: assert property ($changed(buck_two_output_o) |-> $past(ramp_busy_o)
    && (6'(buck_two_output_o - $past(buck_two_output_o)) inside {6'h01, 6'h3F}))
    else $error("buck two step wrong");

  blank_done_c: cover property ($fell(ldo_fault_blank_o));
  refused_c: cover property (ldo_write_refused_o);
  ramp_done_c: cover property ($fell(ramp_busy_o));
endmodule : rail_setpoint_chk

bind rail_setpoint_registers rail_setpoint_chk #(.BLANK_COUNT(BLANK_COUNT)) i_rail_setpoint_chk (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .unlock_i(unlock_i), .buck_one_output_o(buck_one_output_o),
  .buck_two_output_o(buck_two_output_o), .ramp_busy_o(ramp_busy_o),
  .linear_regulator_code_o(linear_regulator_code_o), .linear_regulator_mv_o(linear_regulator_mv_o),
  .ldo_fault_blank_o(ldo_fault_blank_o), .ldo_write_refused_o(ldo_write_refused_o));

/* tb/rail_setpoint_registers_tb.sv */
`timescale 1ns/10ps
module rail_setpoint_registers_tb;
  localparam int BLANK_N = 20;
  logic        core_clk_i          = 1'b0;
  logic        resetn_i            = 1'b0;
  logic [7:0]  reg_addr_i          = 8'h00;
  logic [7:0]  reg_wdata_i         = 8'h00;
  logic        reg_wr_i            = 1'b0;
  logic        reg_rd_i            = 1'b0;
  logic        unlock_i            = 1'b1;
  logic [5:0]  buck_one_setpoint_i = 6'h00;
  logic [5:0]  buck_two_setpoint_i = 6'h00;
  logic        buck_setpoint_wr_i  = 1'b0;
  logic [7:0]  reg_rdata_o;
  logic [5:0]  buck_one_output_o;
  logic [5:0]  buck_two_output_o;
  logic        ramp_busy_o;
  logic [5:0]  linear_regulator_code_o;
  logic [11:0] linear_regulator_mv_o;
  logic        ldo_fault_blank_o;
  logic        ldo_write_refused_o;
  int          n_errors = 0;
  int          n_tests  = 0;

  always #10 core_clk_i = ~core_clk_i;

  rail_setpoint_registers #(.BLANK_COUNT(BLANK_N), .STEP_BASE(1)) i_rail_setpoint_registers (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .unlock_i(unlock_i), .buck_one_setpoint_i(buck_one_setpoint_i),
    .buck_two_setpoint_i(buck_two_setpoint_i), .buck_setpoint_wr_i(buck_setpoint_wr_i),
    .buck_one_output_o(buck_one_output_o), .buck_two_output_o(buck_two_output_o),
    .ramp_busy_o(ramp_busy_o), .linear_regulator_code_o(linear_regulator_code_o),
    .linear_regulator_mv_o(linear_regulator_mv_o), .ldo_fault_blank_o(ldo_fault_blank_o),
    .ldo_write_refused_o(ldo_write_refused_o));

  task report_and_stop;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  task chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task step(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : step

  // returns on the taking edge; callers step before the next strobe, except t_trigger, whose first write goes straight into rdchk
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    step(1);
    reg_wr_i <= 1'b0;
  endtask : wr

  task rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    step(1);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
    step(1);
    chk("rdata", {4'h0, d}, {4'h0, exp});
  endtask : rdchk

  task wait_idle;
    int n;
    n = 0;
    step(3);
    #1;
    while (ramp_busy_o !== 1'b0 && n < 200) begin
      step(1);
      #1;
      n++;
    end
    chk("busy", {11'h0, ramp_busy_o}, 12'h000);
    step(2);
  endtask : wait_idle

  task t_reset;
    rdchk(8'h1A, 8'h06);
    rdchk(8'h1B, 8'h1F);
    rdchk(8'h5A, 8'h00);
    chk("mv", linear_regulator_mv_o, 12'h708);
    chk("bucks", {buck_one_output_o, buck_two_output_o}, 12'h000);
  endtask : t_reset

  task t_reserved;
    wr(8'h1A, 8'h3D);
    step(1);
    rdchk(8'h1A, 8'h05);
    wr(8'h1B, 8'hC5);
    step(1);
    rdchk(8'h1B, 8'h05);
  endtask : t_reserved

  task t_decode;
    logic [5:0] codes [5] = '{6'h00, 6'h19, 6'h1A, 6'h1F, 6'h3F};
    int         mv;
    foreach (codes[i]) begin
      wr(8'h1B, {2'h0, codes[i]});
      #1;
      mv = (codes[i] <= 6'h19) ? 900 + 25 * codes[i] : 1550 + 50 * (codes[i] - 26);
      chk("mv", linear_regulator_mv_o, 12'(mv));
      step(1);
    end
  endtask : t_decode

  task t_lock;
    step(BLANK_N + 5);
    unlock_i <= 1'b0;
    wr(8'h1B, 8'h2A);
    #1;
    chk("refused", {11'h0, ldo_write_refused_o}, 12'h001);
    step(1);
    #1;
    chk("blank", {11'h0, ldo_fault_blank_o}, 12'h000);
    step(1);
    rdchk(8'h1B, 8'h3F);
    unlock_i <= 1'b1;
  endtask : t_lock

  task t_blank;
    int n;
    n = 0;
    wr(8'h1B, 8'h1F);
    #1;
    while (ldo_fault_blank_o === 1'b1 && n < 100) begin
      n++;
      step(1);
      #1;
    end
    chk("blank cycles", 12'(n), 12'(BLANK_N));
    step(1);
  endtask : t_blank

  task t_trigger;
    buck_one_setpoint_i <= 6'h03;
    buck_two_setpoint_i <= 6'h02;
    wr(8'h1A, 8'h87);
    rdchk(8'h1A, 8'h87);
    #1;
    chk("busy", {11'h0, ramp_busy_o}, 12'h001);
    wait_idle;
    chk("bucks", {buck_one_output_o, buck_two_output_o}, 12'h0C2);
    rdchk(8'h1A, 8'h07);
    buck_one_setpoint_i <= 6'h05;
    wr(8'h1A, 8'h07);
    step(10);
    chk("bucks", {buck_one_output_o, buck_two_output_o}, 12'h0C2);
  endtask : t_trigger

  // auto mode on, then off: only the first set-point update may move the rails
  // slew 6 doubles the step interval, so mid-ramp the rails sit one step from the start
  task t_auto;
    wr(8'h1A, 8'h46);
    step(1);
    // lowering buck one: light-load mode taken as already cleared by the host
    buck_one_setpoint_i <= 6'h01;
    buck_two_setpoint_i <= 6'h04;
    buck_setpoint_wr_i  <= 1'b1;
    step(1);
    buck_setpoint_wr_i <= 1'b0;
    step(3);
    #1;
    chk("bucks", {buck_one_output_o, buck_two_output_o}, 12'h083);
    wait_idle;
    chk("bucks", {buck_one_output_o, buck_two_output_o}, 12'h044);
    wr(8'h1A, 8'h07);
    step(1);
    buck_one_setpoint_i <= 6'h02;
    buck_setpoint_wr_i  <= 1'b1;
    step(1);
    buck_setpoint_wr_i <= 1'b0;
    step(10);
    chk("bucks", {buck_one_output_o, buck_two_output_o}, 12'h044);
  endtask : t_auto

  initial begin
    step(10);
    resetn_i <= 1'b1;
    t_reset;
    t_reserved;
    t_decode;
    t_lock;
    t_blank;
    t_trigger;
    t_auto;
    report_and_stop;
  end

  initial begin
    repeat (5000) @(posedge core_clk_i);
    n_errors++;
    report_and_stop;
  end
endmodule : rail_setpoint_registers_tb
